// *** include/prxcfg_map.svh ***
// Register map constants for the proximity configuration and status bank.
// Included by the register bank only; definitions only.
`ifndef PRXCFG_MAP_SVH
`define PRXCFG_MAP_SVH

`define PRXCFG_ADDR_PULSE_TRAIN 8'h8E
`define PRXCFG_ADDR_GAIN_DRIVE 8'h8F
`define PRXCFG_ADDR_REVISION 8'h91
`define PRXCFG_ADDR_PART 8'h92
`define PRXCFG_ADDR_FLAGS 8'h93
`define PRXCFG_ADDR_MISC 8'hAB

`define PRXCFG_PULSE_TRAIN_RST 8'h4F
`define PRXCFG_GAIN_DRIVE_RST 8'h80
`define PRXCFG_MISC_RST 8'h0C
`define PRXCFG_FLAGS_RST 8'h00

`define PRXCFG_BIT_SAT 6
`define PRXCFG_BIT_ALERT 5
`define PRXCFG_BIT_CAL 3
`define PRXCFG_BIT_ZERO 2
`define PRXCFG_BIT_SAT_REFL 1
`define PRXCFG_BIT_SAT_AMB 0
`define PRXCFG_BIT_READ_CLEAR 7

`define PRXCFG_FLAGS_MASK 8'h6F
`define PRXCFG_GAIN_DRIVE_MASK 8'hDF
`define PRXCFG_MISC_MASK 8'h9F

`endif

// *** include/prxcfg_pkg.sv ***
// Types for the proximity configuration and status bank.
// Constants live in prxcfg_map.svh.
package prxcfg_pkg;
    typedef enum logic [1:0] {
        PRXCFG_PW_4US,
        PRXCFG_PW_8US,
        PRXCFG_PW_16US,
        PRXCFG_PW_32US
    } prxcfg_pulse_width_type;
    typedef enum logic [1:0] {
        PRXCFG_GAIN_1X,
        PRXCFG_GAIN_2X,
        PRXCFG_GAIN_4X,
        PRXCFG_GAIN_8X
    } prxcfg_gain_type;
endpackage

// *** rtl/prxcfg_regs.sv ***
// Proximity configuration and status register bank.
// Assumes a serial-link slave on clk_sys delivering one-cycle read and
// write strobes with an 8-bit address; engine events are same-clock pulses.
`timescale 1ns/1ps
`default_nettype none
`include "prxcfg_map.svh"

module prxcfg_regs #(
    // Arbitrary neutral identity values
    parameter logic [2:0] REVISION_VALUE = 3'h1,
    parameter logic [5:0] PART_VALUE = 6'h2A
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic sat_refl_evt,
    input wire logic sat_amb_evt,
    input wire logic prox_alert_evt,
    input wire logic cal_evt,
    input wire logic zero_evt,
    input wire logic alert_enable,
    output prxcfg_pkg::prxcfg_pulse_width_type pulse_width,
    output logic [6:0] pulse_count,
    output prxcfg_pkg::prxcfg_gain_type rx_gain,
    output logic [7:0] led_current_ma,
    output logic int_n
);
    import prxcfg_pkg::*;

    logic [7:0] pulse_train_config_ff, nxt_pulse_train_config;
    logic [7:0] gain_and_drive_config_ff, nxt_gain_and_drive_config;
    logic [7:0] misc_config_ff, nxt_misc_config;
    logic [7:0] event_flags_ff, nxt_event_flags;
    logic [7:0] reg_rdata_ff, nxt_reg_rdata;
    logic int_n_ff, nxt_int_n;
    logic [1:0] pulse_width_ff, nxt_pulse_width;
    logic [6:0] pulse_count_ff, nxt_pulse_count;
    logic [1:0] rx_gain_ff, nxt_rx_gain;
    logic [7:0] led_current_ff, nxt_led_current;
    logic [7:0] clr_mask;
    logic [7:0] set_mask;

    always_comb begin
        nxt_pulse_train_config = pulse_train_config_ff;
        nxt_gain_and_drive_config = gain_and_drive_config_ff;
        nxt_misc_config = misc_config_ff;
        if (reg_wr) begin
            if (reg_addr == `PRXCFG_ADDR_PULSE_TRAIN) begin
                nxt_pulse_train_config = reg_wdata;
            end
            if (reg_addr == `PRXCFG_ADDR_GAIN_DRIVE) begin
                nxt_gain_and_drive_config = reg_wdata & `PRXCFG_GAIN_DRIVE_MASK;
            end
            if (reg_addr == `PRXCFG_ADDR_MISC) begin
                nxt_misc_config = reg_wdata & `PRXCFG_MISC_MASK;
            end
        end
    end

    always_comb begin
        clr_mask = 8'h00;
        set_mask = 8'h00;
        if (reg_wr && reg_addr == `PRXCFG_ADDR_FLAGS) begin
            clr_mask = reg_wdata & `PRXCFG_FLAGS_MASK;
            if (reg_wdata[`PRXCFG_BIT_SAT]) begin
                clr_mask[`PRXCFG_BIT_SAT_REFL] = 1'b1;
                clr_mask[`PRXCFG_BIT_SAT_AMB] = 1'b1;
            end
        end
        if (reg_rd && reg_addr == `PRXCFG_ADDR_FLAGS &&
            misc_config_ff[`PRXCFG_BIT_READ_CLEAR]) begin
            clr_mask = `PRXCFG_FLAGS_MASK;
        end
        set_mask[`PRXCFG_BIT_SAT] = sat_refl_evt | sat_amb_evt;
        set_mask[`PRXCFG_BIT_SAT_REFL] = sat_refl_evt;
        set_mask[`PRXCFG_BIT_SAT_AMB] = sat_amb_evt;
        set_mask[`PRXCFG_BIT_ALERT] = prox_alert_evt;
        set_mask[`PRXCFG_BIT_CAL] = cal_evt;
        set_mask[`PRXCFG_BIT_ZERO] = zero_evt;
        // Events arriving with a clear win, so none is lost
        nxt_event_flags = (event_flags_ff & ~clr_mask) | set_mask;
    end

    always_comb begin
        nxt_reg_rdata = reg_rdata_ff;
        if (reg_rd) begin
            unique case (reg_addr)
                `PRXCFG_ADDR_PULSE_TRAIN: nxt_reg_rdata = pulse_train_config_ff;
                `PRXCFG_ADDR_GAIN_DRIVE: nxt_reg_rdata = gain_and_drive_config_ff;
                `PRXCFG_ADDR_REVISION: nxt_reg_rdata = {5'h00, REVISION_VALUE};
                `PRXCFG_ADDR_PART: nxt_reg_rdata = {PART_VALUE, 2'h0};
                `PRXCFG_ADDR_FLAGS: nxt_reg_rdata = event_flags_ff;
                `PRXCFG_ADDR_MISC: nxt_reg_rdata = misc_config_ff;
                default: nxt_reg_rdata = 8'h00;
            endcase
        end
    end

    always_comb begin
        nxt_pulse_width = nxt_pulse_train_config[7:6];
        nxt_pulse_count = {1'b0, nxt_pulse_train_config[5:0]} + 7'h01;
        nxt_rx_gain = nxt_gain_and_drive_config[7:6];
        // 6 mA per step, code plus one
        nxt_led_current = 8'({3'h0, nxt_gain_and_drive_config[4:0]} + 8'h01) * 8'h06;
        nxt_int_n = ~(nxt_event_flags[`PRXCFG_BIT_ALERT] & alert_enable);
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            pulse_train_config_ff <= `PRXCFG_PULSE_TRAIN_RST;
            gain_and_drive_config_ff <= `PRXCFG_GAIN_DRIVE_RST;
            misc_config_ff <= `PRXCFG_MISC_RST;
            event_flags_ff <= `PRXCFG_FLAGS_RST;
            reg_rdata_ff <= 8'h00;
            int_n_ff <= 1'b1;
            pulse_width_ff <= 2'h1;
            pulse_count_ff <= 7'h10;
            rx_gain_ff <= 2'h2;
            led_current_ff <= 8'h06;
        end else begin
            pulse_train_config_ff <= nxt_pulse_train_config;
            gain_and_drive_config_ff <= nxt_gain_and_drive_config;
            misc_config_ff <= nxt_misc_config;
            event_flags_ff <= nxt_event_flags;
            reg_rdata_ff <= nxt_reg_rdata;
            int_n_ff <= nxt_int_n;
            pulse_width_ff <= nxt_pulse_width;
            pulse_count_ff <= nxt_pulse_count;
            rx_gain_ff <= nxt_rx_gain;
            led_current_ff <= nxt_led_current;
        end
    end

    assign reg_rdata = reg_rdata_ff;
    assign int_n = int_n_ff;
    assign pulse_width = prxcfg_pulse_width_type'(pulse_width_ff);
    assign pulse_count = pulse_count_ff;
    assign rx_gain = prxcfg_gain_type'(rx_gain_ff);
    assign led_current_ma = led_current_ff;

    sat_sticky_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        event_flags_ff[6] && !(reg_wr && reg_addr == 8'h93 && reg_wdata[6]) && !reg_rd
        |=> event_flags_ff[6])
        else $error("saturation flag dropped without clear");
    alert_set_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        prox_alert_evt |=> event_flags_ff[5])
        else $error("alert flag not set");
    cal_w1c_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        reg_wr && reg_addr == 8'h93 && !reg_wdata[3] && event_flags_ff[3] && !reg_rd
        |=> event_flags_ff[3])
        else $error("zero write cleared calibration flag");
    zero_clear_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        reg_wr && reg_addr == 8'h93 && reg_wdata[2] && !zero_evt |=> !event_flags_ff[2])
        else $error("zero flag not cleared");
    refl_clear_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        reg_wr && reg_addr == 8'h93 && reg_wdata[6] && !sat_refl_evt |=> !event_flags_ff[1])
        else $error("reflective flag survived bit6 clear");
    amb_clear_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        reg_wr && reg_addr == 8'h93 && reg_wdata[6] && !sat_amb_evt |=> !event_flags_ff[0])
        else $error("ambient flag survived bit6 clear");
    read_keep_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        reg_rd && reg_addr == 8'h93 && !misc_config_ff[7] && !reg_wr &&
        !(sat_refl_evt | sat_amb_evt | prox_alert_evt | cal_evt | zero_evt)
        |=> event_flags_ff == $past(event_flags_ff))
        else $error("read changed flags while disabled");
    read_clear_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        reg_rd && reg_addr == 8'h93 && misc_config_ff[7] && !cal_evt |=> !event_flags_ff[3])
        else $error("enabled read did not clear");
    int_drive_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        prox_alert_evt && alert_enable |=> !int_n)
        else $error("interrupt not asserted");
    int_release_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        !event_flags_ff[5] |-> int_n)
        else $error("interrupt held after clear");
    led_step_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        led_current_ma == 8'(({3'h0, gain_and_drive_config_ff[4:0]} + 8'h01) * 8'h06))
        else $error("LED current mismatch");
    count_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        pulse_count == {1'b0, pulse_train_config_ff[5:0]} + 7'h01)
        else $error("pulse count mismatch");
    gain_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        !gain_and_drive_config_ff[5] && rx_gain == gain_and_drive_config_ff[7:6])
        else $error("gain field mismatch");
endmodule
`default_nettype wire

// *** test/prxcfg_host_model.sv ***
// Host side model: single-byte register reads and writes.
// Assumes the bank samples strobes on the same clk_sys edge.
`timescale 1ns/1ps
`default_nettype none
module prxcfg_host_model (
    input wire logic clk_sys,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end
    // Idle bus shows inverted values so stale data never looks valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(negedge clk_sys);
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// *** test/prxcfg_regs_tb_top.sv ***
// Testbench for the proximity configuration and status bank.
// Assumes the host model file is compiled first.
`timescale 1ns/1ps
`default_nettype none
module prxcfg_regs_tb_top;
    import prxcfg_pkg::*;
    logic clk_sys, rstn, reg_wr, reg_rd, alert_enable, int_n;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, led_current_ma;
    logic [4:0] evt, code;
    logic [6:0] pulse_count;
    prxcfg_pulse_width_type pulse_width;
    prxcfg_gain_type rx_gain;
    int error_cnt, num_checks, cyc;
    logic [7:0] ra [7] = '{8'h8E, 8'h8F, 8'h91, 8'h92, 8'h93, 8'hAB, 8'h90};
    logic [7:0] re [7] = '{8'h4F, 8'h80, 8'h01, 8'hA8, 8'h00, 8'h0C, 8'h00};
    prxcfg_host_model host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    prxcfg_regs DUT (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sat_refl_evt(evt[4]), .sat_amb_evt(evt[3]), .prox_alert_evt(evt[2]),
        .cal_evt(evt[1]), .zero_evt(evt[0]), .alert_enable(alert_enable),
        .pulse_width(pulse_width), .pulse_count(pulse_count), .rx_gain(rx_gain),
        .led_current_ma(led_current_ma), .int_n(int_n));
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.rd(a, d);
        chk8(d, e);
    endtask
    // Config outputs update on the same edge as the write
    task automatic settle;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    task automatic pulse(input logic [4:0] e);
        @(posedge clk_sys);
        evt <= e;
        @(posedge clk_sys);
        evt <= 5'h00;
    endtask
    task automatic test_done;
        if (error_cnt == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    initial begin
        cyc = 0;
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            test_done();
        end
    end
    initial begin
        rstn = 1'b0;
        evt = 5'h00;
        alert_enable = 1'b1;
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;
        @(negedge clk_sys);
        chk8({2'b00, pulse_width, rx_gain, 1'b0, int_n}, 8'h19); // reset codes
        chk8({1'b0, pulse_count}, 8'h10); // reset count
        chk8(led_current_ma, 8'h06); // reset current
        foreach (ra[i]) rchk(ra[i], re[i]); // reset values and unmapped
        host.wr(8'h91, 8'hFF);
        rchk(8'h91, 8'h01); // read-only revision
        for (int i = 0; i < 4; i++) begin
            host.wr(8'h8E, {2'(i), 6'(i * 21)});
            code = (i == 3) ? 5'h1F : 5'(i * 10);
            host.wr(8'h8F, {2'(i), 1'b1, code});
            settle();
            chk8(8'(pulse_width), 8'(i)); // width code
            chk8({1'b0, pulse_count}, 8'(i * 21 + 1)); // count plus one
            chk8(8'(rx_gain), 8'(i)); // gain code
            chk8(led_current_ma, 8'((code + 1) * 6)); // six mA steps
            rchk(8'h8F, {2'(i), 1'b0, code}); // reserved bit
        end
        pulse(5'h1F);
        settle();
        chk8({7'h00, int_n}, 8'h00); // line driven low
        rchk(8'h93, 8'h6F); // flags set
        rchk(8'h93, 8'h6F); // read keeps flags
        @(posedge clk_sys);
        alert_enable <= 1'b0;
        settle();
        chk8({7'h00, int_n}, 8'h01); // gated by enable
        @(posedge clk_sys);
        alert_enable <= 1'b1;
        host.wr(8'h93, 8'h08);
        rchk(8'h93, 8'h67); // calibration cleared
        host.wr(8'h93, 8'h00);
        rchk(8'h93, 8'h67); // zero write keeps
        host.wr(8'h93, 8'h40);
        rchk(8'h93, 8'h24); // saturation group
        pulse(5'h10);
        host.wr(8'h93, 8'h02);
        rchk(8'h93, 8'h64); // reflective own bit
        pulse(5'h08);
        host.wr(8'h93, 8'h01);
        rchk(8'h93, 8'h64); // ambient own bit
        chk8({7'h00, int_n}, 8'h00); // still asserted
        host.wr(8'h93, 8'h20);
        settle();
        chk8({7'h00, int_n}, 8'h01); // released
        host.wr(8'h93, 8'h04);
        rchk(8'h93, 8'h40); // zero cleared
        host.wr(8'hAB, 8'hFF);
        rchk(8'hAB, 8'h9F); // control bit stored
        pulse(5'h05);
        settle();
        rchk(8'h93, 8'h64); // read returns flags
        rchk(8'h93, 8'h00); // read cleared
        chk8({7'h00, int_n}, 8'h01); // released on read
        test_done();
    end
endmodule
`default_nettype wire
